// >>> hw/dtcc_top.sv
/*
  Control slice of the debug trace unit: control register, comparator C with its
  direction qualifier and loop suppression, and FIFO word formation with extended info.
  Assumes a CPU-side register port, a bus-monitor feed, change-of-flow events and a
  trigger pulse from the excluded trigger logic, all synchronous to clk_sys.
*/
`timescale 1ns/1ps
module dtcc_top (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic end_run_reset,
  input wire logic secure,
  input wire logic trig_begin,
  input wire logic event_only_mode,
  input wire logic trig_hit,
  input wire dtcc_pkg::dtcc_reg_req_t reg_req,
  input wire dtcc_pkg::dtcc_bus_t bus_mon,
  input wire dtcc_pkg::dtcc_cof_t cof_in,
  output logic [dtcc_pkg::DATA_W-1:0] reg_rdata,
  output logic fifo_wr,
  output dtcc_pkg::dtcc_fifo_word_t fifo_wdata,
  output logic cmp_c_match,
  output logic brk_req,
  output logic brk_tag,
  output logic irq
);

  typedef struct packed {
    dtcc_pkg::dtcc_ctl_t ctl;
    logic dir_en;
    logic dir_val;
    logic [dtcc_pkg::CORE_AW-1:0] cmp_addr;
    logic fx_paged;
    logic fx_msb;
    logic [7:0] count;
    logic [3:0] status;
    logic [3:0] mask;
    dtcc_pkg::dtcc_run_t run;
    logic [dtcc_pkg::DATA_W-1:0] rdata;
    logic fifo_wr;
    dtcc_pkg::dtcc_fifo_word_t fifo_word;
    logic match;
    logic brk_req;
    logic brk_tag;
    logic irq;
  } dtcc_state_t;

  logic [1:0] rst_sync_r;
  logic rst_n_int;
  dtcc_state_t st_r;
  dtcc_state_t st_nxt;

  // Forms the stored word: paged accesses keep page and 14 low bits, others bit 16 zero.
  function automatic dtcc_pkg::dtcc_fifo_word_t dtcc_form_word(input dtcc_pkg::dtcc_cof_t c);
    dtcc_pkg::dtcc_fifo_word_t w;
    w.paged = c.paged;
    if (c.paged)
    begin
      w.word = {c.page, c.addr[dtcc_pkg::PAGE_LOW_W-1:0]};
    end
    else
    begin
      w.word = {1'b0, c.addr[dtcc_pkg::CORE_AW-2:0]};
    end
    return w;
  endfunction : dtcc_form_word

  // Direction check shared by bus matching.
  function automatic logic dtcc_dir_ok(input logic en, input logic val, input logic is_read);
    return !en || (val == is_read);
  endfunction : dtcc_dir_ok

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_sync_r <= 2'h0;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n_int = rst_sync_r[1];

  always_comb
  begin
    logic active;
    logic bus_hit;
    logic storing;
    logic cof_ok;
    logic cof_same;
    logic run_end;
    logic [3:0] evt;
    logic keep_ext;
    dtcc_pkg::dtcc_fifo_word_t w;
    active = 1'b0;
    bus_hit = 1'b0;
    storing = 1'b0;
    cof_ok = 1'b0;
    cof_same = 1'b0;
    run_end = 1'b0;
    evt = dtcc_pkg::EVT_NONE;
    keep_ext = 1'b0;
    w = dtcc_form_word(cof_in);
    st_nxt = st_r;
    st_nxt.fifo_wr = 1'b0;
    st_nxt.rdata = dtcc_pkg::REG_RESET;

    active = st_r.ctl.enable && st_r.ctl.arm;
    bus_hit = active && bus_mon.valid && (bus_mon.addr == st_r.cmp_addr)
      && dtcc_dir_ok(st_r.dir_en, st_r.dir_val, bus_mon.is_read);
    st_nxt.match = bus_hit;

    // Run sequencing follows the trigger position select.
    unique case (st_r.run)
      dtcc_pkg::DTCC_RUN_IDLE:
      begin
        storing = 1'b0;
      end
      dtcc_pkg::DTCC_RUN_WAIT:
      begin
        if (trig_hit)
        begin
          st_nxt.run = dtcc_pkg::DTCC_RUN_STORE;
        end
      end
      dtcc_pkg::DTCC_RUN_STORE:
      begin
        storing = 1'b1;
        if (!trig_begin && trig_hit)
        begin
          run_end = 1'b1;
        end
      end
      default:
      begin
        st_nxt.run = dtcc_pkg::DTCC_RUN_IDLE;
      end
    endcase

    cof_ok = active && storing && !run_end && cof_in.valid && !event_only_mode;
    cof_same = st_r.ctl.loop_sup && (w.word == st_r.cmp_addr);
    if (cof_ok && cof_same)
    begin
      evt[dtcc_pkg::EVT_SUPPRESS] = 1'b1;
    end
    else if (cof_ok)
    begin
      st_nxt.fifo_wr = 1'b1;
      st_nxt.fifo_word = w;
      st_nxt.fx_paged = w.paged;
      st_nxt.fx_msb = w.word[dtcc_pkg::CORE_AW-1];
      st_nxt.count = st_r.count + dtcc_pkg::COUNT_ONE;
      evt[dtcc_pkg::EVT_CAPTURE] = 1'b1;
      if (st_r.ctl.loop_sup)
      begin
        st_nxt.cmp_addr = w.word;
      end
      if (trig_begin && (st_r.count + dtcc_pkg::COUNT_ONE == dtcc_pkg::FIFO_DEPTH))
      begin
        run_end = 1'b1;
      end
    end

    if (run_end)
    begin
      st_nxt.run = dtcc_pkg::DTCC_RUN_IDLE;
      st_nxt.ctl.arm = 1'b0;
      evt[dtcc_pkg::EVT_RUN_END] = 1'b1;
    end
    if (bus_hit)
    begin
      evt[dtcc_pkg::EVT_CMP_C_MATCH] = 1'b1;
    end

    st_nxt.brk_req = st_r.ctl.brk_en && (run_end || bus_hit);
    st_nxt.brk_tag = st_r.ctl.brk_en && st_r.ctl.tag;

    // Register port: reads answer next cycle, writes act next cycle.
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        dtcc_pkg::OFF_CONTROL:
        begin
          st_nxt.rdata = {st_r.ctl.enable, st_r.ctl.arm, st_r.ctl.tag, st_r.ctl.brk_en,
            3'h0, st_r.ctl.loop_sup};
        end
        dtcc_pkg::OFF_CMP_C_EXT:
        begin
          st_nxt.rdata = {st_r.dir_en, st_r.dir_val, 6'h00};
        end
        dtcc_pkg::OFF_FIFO_EXT:
        begin
          st_nxt.rdata = {st_r.fx_paged, 6'h00, st_r.fx_msb};
        end
        dtcc_pkg::OFF_CMP_C_ADDR_HI:
        begin
          st_nxt.rdata = {7'h00, st_r.cmp_addr[16]};
        end
        dtcc_pkg::OFF_CMP_C_ADDR_MID:
        begin
          st_nxt.rdata = st_r.cmp_addr[15:8];
        end
        dtcc_pkg::OFF_CMP_C_ADDR_LO:
        begin
          st_nxt.rdata = st_r.cmp_addr[7:0];
        end
        dtcc_pkg::OFF_EVT_STATUS:
        begin
          st_nxt.rdata = {4'h0, st_r.status};
        end
        dtcc_pkg::OFF_EVT_MASK:
        begin
          st_nxt.rdata = {4'h0, st_r.mask};
        end
        dtcc_pkg::OFF_FIFO_COUNT:
        begin
          st_nxt.rdata = st_r.count;
        end
        default:
        begin
          st_nxt.rdata = dtcc_pkg::REG_RESET;
        end
      endcase
    end

    st_nxt.status = st_r.status;
    if (reg_req.wr)
    begin
      unique case (reg_req.addr)
        dtcc_pkg::OFF_CONTROL:
        begin
          st_nxt.ctl.enable = reg_req.wdata[dtcc_pkg::CTL_ENABLE_BIT];
          st_nxt.ctl.arm = reg_req.wdata[dtcc_pkg::CTL_ARM_BIT];
          st_nxt.ctl.tag = reg_req.wdata[dtcc_pkg::CTL_TAG_BIT];
          st_nxt.ctl.brk_en = reg_req.wdata[dtcc_pkg::CTL_BREAK_REQUEST_ENABLE_BIT];
          st_nxt.ctl.loop_sup = reg_req.wdata[dtcc_pkg::CTL_LOOP_BIT];
          if (reg_req.wdata[dtcc_pkg::CTL_ARM_BIT] && !st_r.ctl.arm)
          begin
            st_nxt.count = dtcc_pkg::REG_RESET;
            st_nxt.run = trig_begin ? dtcc_pkg::DTCC_RUN_WAIT : dtcc_pkg::DTCC_RUN_STORE;
          end
          else if (!reg_req.wdata[dtcc_pkg::CTL_ARM_BIT])
          begin
            st_nxt.run = dtcc_pkg::DTCC_RUN_IDLE;
          end
        end
        dtcc_pkg::OFF_CMP_C_EXT:
        begin
          st_nxt.dir_en = reg_req.wdata[dtcc_pkg::CCX_DIR_EN_BIT];
          st_nxt.dir_val = reg_req.wdata[dtcc_pkg::CCX_DIR_VAL_BIT];
        end
        dtcc_pkg::OFF_CMP_C_ADDR_HI:
        begin
          st_nxt.cmp_addr[16] = reg_req.wdata[0];
        end
        dtcc_pkg::OFF_CMP_C_ADDR_MID:
        begin
          st_nxt.cmp_addr[15:8] = reg_req.wdata;
        end
        dtcc_pkg::OFF_CMP_C_ADDR_LO:
        begin
          st_nxt.cmp_addr[7:0] = reg_req.wdata;
        end
        dtcc_pkg::OFF_EVT_STATUS:
        begin
          st_nxt.status = st_r.status & ~reg_req.wdata[3:0];
        end
        dtcc_pkg::OFF_EVT_MASK:
        begin
          st_nxt.mask = reg_req.wdata[3:0];
        end
        default:
        begin
          st_nxt.mask = st_r.mask;
        end
      endcase
    end
    // A new event wins over a clear in the same cycle.
    st_nxt.status = st_nxt.status | evt;

    // The enable bit is forced low and cannot be set while secured.
    if (secure)
    begin
      st_nxt.ctl.enable = 1'b0;
    end
    if (!st_nxt.ctl.enable)
    begin
      st_nxt.ctl.arm = 1'b0;
      st_nxt.run = dtcc_pkg::DTCC_RUN_IDLE;
    end

    // An end-run reset keeps the extension registers only in trigger-end mode
    // with the unit enabled; arming and break enable are always dropped.
    if (end_run_reset)
    begin
      keep_ext = st_r.ctl.enable && !trig_begin;
      st_nxt.ctl.arm = 1'b0;
      st_nxt.ctl.brk_en = 1'b0;
      st_nxt.run = dtcc_pkg::DTCC_RUN_IDLE;
      st_nxt.fifo_wr = 1'b0;
      st_nxt.brk_req = 1'b0;
      st_nxt.match = 1'b0;
      if (!keep_ext)
      begin
        st_nxt.dir_en = 1'b0;
        st_nxt.dir_val = 1'b0;
        st_nxt.fx_paged = 1'b0;
        st_nxt.fx_msb = 1'b0;
      end
      else
      begin
        st_nxt.dir_en = st_r.dir_en;
        st_nxt.dir_val = st_r.dir_val;
        st_nxt.fx_paged = st_r.fx_paged;
        st_nxt.fx_msb = st_r.fx_msb;
      end
    end

    st_nxt.irq = |(st_nxt.status & st_nxt.mask);
  end

  always_ff @(posedge clk_sys or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign fifo_wr = st_r.fifo_wr;
  assign fifo_wdata = st_r.fifo_word;
  assign cmp_c_match = st_r.match;
  assign brk_req = st_r.brk_req;
  assign brk_tag = st_r.brk_tag;
  assign irq = st_r.irq;

endmodule : dtcc_top

// >>> hw/dtcc_pkg.sv
/*
  Constants and carrier types for the debug trace control slice around comparator C.
  Assumes an 8-bit register port with byte offsets and a 17-bit core address space.
*/
package dtcc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CORE_AW = 17;

  // Register offsets.
  localparam logic [7:0] OFF_CONTROL = 8'h0C;
  localparam logic [7:0] OFF_CMP_C_EXT = 8'h10;
  localparam logic [7:0] OFF_FIFO_EXT = 8'h14;
  localparam logic [7:0] OFF_CMP_C_ADDR_HI = 8'h18;
  localparam logic [7:0] OFF_CMP_C_ADDR_MID = 8'h1C;
  localparam logic [7:0] OFF_CMP_C_ADDR_LO = 8'h20;
  localparam logic [7:0] OFF_EVT_STATUS = 8'h24;
  localparam logic [7:0] OFF_EVT_MASK = 8'h28;
  localparam logic [7:0] OFF_FIFO_COUNT = 8'h2C;

  // Control register fields.
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_ARM_BIT = 6;
  localparam int CTL_TAG_BIT = 5;
  localparam int CTL_BREAK_REQUEST_ENABLE_BIT = 4;
  localparam int CTL_LOOP_BIT = 0;
  localparam logic [7:0] CTL_WRITE_MASK = 8'hF1;

  // Comparator C extension fields.
  localparam int CCX_DIR_EN_BIT = 7;
  localparam int CCX_DIR_VAL_BIT = 6;
  localparam logic [7:0] CCX_WRITE_MASK = 8'hC0;

  // FIFO extended-info fields.
  localparam int FX_PAGED_BIT = 7;
  localparam int FX_MSB_BIT = 0;

  // Event status bits.
  localparam int EVT_CMP_C_MATCH = 0;
  localparam int EVT_CAPTURE = 1;
  localparam int EVT_RUN_END = 2;
  localparam int EVT_SUPPRESS = 3;
  localparam logic [3:0] EVT_NONE = 4'h0;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] FIFO_DEPTH = 8'h08;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam int PAGE_W = 3;
  localparam int PAGE_LOW_W = 14;

  typedef enum logic [1:0] {
    DTCC_RUN_IDLE = 2'b00,
    DTCC_RUN_WAIT = 2'b01,
    DTCC_RUN_STORE = 2'b10
  } dtcc_run_t;

  typedef struct packed {
    logic enable;
    logic arm;
    logic tag;
    logic brk_en;
    logic loop_sup;
  } dtcc_ctl_t;

  typedef struct packed {
    logic valid;
    logic is_read;
    logic [CORE_AW-1:0] addr;
  } dtcc_bus_t;

  typedef struct packed {
    logic valid;
    logic paged;
    logic [PAGE_W-1:0] page;
    logic [CORE_AW-1:0] addr;
  } dtcc_cof_t;

  typedef struct packed {
    logic paged;
    logic [CORE_AW-1:0] word;
  } dtcc_fifo_word_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } dtcc_reg_req_t;

endpackage : dtcc_pkg

// >>> dv/dtcc_monitor.sv
/*
  Port-level checker for the comparator C debug slice.
  Assumes binding to dtcc_top and the package constants for offsets.
*/
`timescale 1ns/1ps
module dtcc_monitor (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic secure,
  input wire logic event_only_mode,
  input wire dtcc_pkg::dtcc_reg_req_t reg_req,
  input wire dtcc_pkg::dtcc_bus_t bus_mon,
  input wire dtcc_pkg::dtcc_cof_t cof_in,
  input wire logic [7:0] reg_rdata,
  input wire logic fifo_wr,
  input wire dtcc_pkg::dtcc_fifo_word_t fifo_wdata,
  input wire logic cmp_c_match,
  input wire logic brk_req,
  input wire logic brk_tag
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  sequence s_rd(a);
    $past(reg_req.rd) && $past(reg_req.addr) == a;
  endsequence
  AST_PAGED_FLAG: assert property (fifo_wr |-> fifo_wdata.paged == $past(cof_in.paged))
    else $error("paged flag differs from event");
  AST_PAGED_WORD: assert property (fifo_wr && fifo_wdata.paged |->
    fifo_wdata.word == {$past(cof_in.page), $past(cof_in.addr[13:0])})
    else $error("paged word layout wrong");
  AST_FLAT_WORD: assert property (fifo_wr && !fifo_wdata.paged |->
    fifo_wdata.word == {1'b0, $past(cof_in.addr[15:0])})
    else $error("unpaged word layout wrong");
  AST_CAPTURE_CAUSE: assert property (fifo_wr |->
    $past(cof_in.valid) && !$past(event_only_mode))
    else $error("capture without a qualifying event");
  AST_MATCH_CAUSE: assert property (cmp_c_match |-> $past(bus_mon.valid))
    else $error("match without a bus access");
  AST_RDATA_IDLE: assert property (reg_rdata != 8'h00 |-> $past(reg_req.rd))
    else $error("read data outside the answer cycle");
  AST_CTL_RSVD: assert property (s_rd(dtcc_pkg::OFF_CONTROL) |-> reg_rdata[3:1] == 3'h0)
    else $error("control reserved bits nonzero");
  AST_CCX_RSVD: assert property (s_rd(dtcc_pkg::OFF_CMP_C_EXT) |-> reg_rdata[5:0] == 6'h00)
    else $error("extension reserved bits nonzero");
  AST_FX_RSVD: assert property (s_rd(dtcc_pkg::OFF_FIFO_EXT) |-> reg_rdata[6:1] == 6'h00)
    else $error("extended info reserved bits nonzero");
  AST_SECURE_EN: assert property (s_rd(dtcc_pkg::OFF_CONTROL)
    ##0 $past(secure) && $past(secure, 2) |-> !reg_rdata[7])
    else $error("enable set while secured");
  cover property (fifo_wr && fifo_wdata.paged);
  cover property (cmp_c_match && brk_tag);
  cover property (brk_req && !cmp_c_match);
endmodule : dtcc_monitor

// >>> dv/dtcc_cpu_model.sv
/*
  CPU core partner: drives monitored bus accesses and counts break requests that come with brk_tag set.
  Assumes the bench calls acc right after a rising edge of clk_sys.
*/
`timescale 1ns/1ps
module dtcc_cpu_model (
  input wire logic clk_sys,
  input wire logic brk_req,
  input wire logic brk_tag,
  output dtcc_pkg::dtcc_bus_t bus_mon
);
  int n_tag = 0;
  initial bus_mon = '0;
  always @(posedge clk_sys)
    if (brk_req && brk_tag)
      n_tag++;
  // A released bus shows the inverse of the last access.
  task acc(input logic [16:0] a, input logic r);
    @(posedge clk_sys);
    bus_mon <= '{valid: 1'b1, is_read: r, addr: a};
    @(posedge clk_sys);
    bus_mon <= '{valid: 1'b0, is_read: ~r, addr: ~a};
  endtask : acc
endmodule : dtcc_cpu_model

// >>> dv/dtcc_tb_top.sv
/*
  Testbench for the comparator C debug slice; each scenario is one task.
  Assumes the package, the CPU model and the checker are compiled first.
*/
`timescale 1ns/1ps
module dtcc_tb_top;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic end_run_reset = 1'b0;
  logic secure = 1'b0;
  logic trig_begin = 1'b0;
  logic event_only_mode = 1'b0;
  logic trig_hit = 1'b0;
  dtcc_pkg::dtcc_reg_req_t reg_req = '0;
  dtcc_pkg::dtcc_bus_t bus_mon;
  dtcc_pkg::dtcc_cof_t cof_in = '0;
  logic [7:0] reg_rdata;
  logic fifo_wr;
  dtcc_pkg::dtcc_fifo_word_t fifo_wdata;
  logic cmp_c_match;
  logic brk_req;
  logic brk_tag;
  logic irq;
  int miscompares = 0;
  int total_checks = 0;
  always #10 clk_sys = ~clk_sys;
  dtcc_top dut (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .end_run_reset(end_run_reset),
    .secure(secure),
    .trig_begin(trig_begin),
    .event_only_mode(event_only_mode),
    .trig_hit(trig_hit),
    .reg_req(reg_req),
    .bus_mon(bus_mon),
    .cof_in(cof_in),
    .reg_rdata(reg_rdata),
    .fifo_wr(fifo_wr),
    .fifo_wdata(fifo_wdata),
    .cmp_c_match(cmp_c_match),
    .brk_req(brk_req),
    .brk_tag(brk_tag),
    .irq(irq)
  );
  dtcc_cpu_model cpu (
    .clk_sys(clk_sys),
    .brk_req(brk_req),
    .brk_tag(brk_tag),
    .bus_mon(bus_mon)
  );
  task chk(input string n, input logic [17:0] e, input logic [17:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    reg_req.wr <= 1'b0;
  endtask : wr
  task rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    reg_req.rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {10'h000, e}, {10'h000, reg_rdata});
  endtask : rchk
  task bus(input logic [16:0] a, input logic r, input logic em, input logic eb);
    cpu.acc(a, r);
    #1;
    chk("cmp_c_match", {17'h0, em}, {17'h0, cmp_c_match});
    chk("brk_req", {17'h0, eb}, {17'h0, brk_req});
  endtask : bus
  task change_of_flow(input logic p, input logic [2:0] pg, input logic [16:0] a, input logic [18:0] e);
    @(posedge clk_sys);
    cof_in <= '{valid: 1'b1, paged: p, page: pg, addr: a};
    @(posedge clk_sys);
    cof_in <= '{valid: 1'b0, paged: ~p, page: ~pg, addr: ~a};
    #1;
    chk("fifo_wr", {17'h0, e[18]}, {17'h0, fifo_wr});
    if (e[18])
      chk("fifo_wdata", e[17:0], fifo_wdata);
  endtask : change_of_flow
  task t_regs;
    rchk(8'h0C, 8'h00);
    rchk(8'h10, 8'h00);
    rchk(8'h14, 8'h00);
    rchk(8'h04, 8'h00);
    wr(8'h10, 8'hFF);
    rchk(8'h10, 8'hC0);
    secure <= 1'b1;
    wr(8'h0C, 8'hFF);
    rchk(8'h0C, 8'h31);
    secure <= 1'b0;
    wr(8'h0C, 8'h00);
    wr(8'h10, 8'h00);
    $display("t_regs done");
  endtask : t_regs
  task t_cmp;
    wr(8'h18, 8'h01);
    wr(8'h1C, 8'h23);
    wr(8'h20, 8'h45);
    bus(17'h12345, 1'b0, 1'b0, 1'b0);
    wr(8'h0C, 8'hD0);
    bus(17'h12345, 1'b0, 1'b1, 1'b1);
    chk("brk_tag", 18'h0, {17'h0, brk_tag});
    bus(17'h12344, 1'b0, 1'b0, 1'b0);
    wr(8'h10, 8'hC0);
    bus(17'h12345, 1'b0, 1'b0, 1'b0);
    bus(17'h12345, 1'b1, 1'b1, 1'b1);
    wr(8'h0C, 8'hF0);
    bus(17'h12345, 1'b1, 1'b1, 1'b1);
    wr(8'h0C, 8'hC0);
    bus(17'h12345, 1'b1, 1'b1, 1'b0);
    chk("n_tag", 18'h1, cpu.n_tag[17:0]);
    $display("t_cmp done");
  endtask : t_cmp
  task t_cap;
    wr(8'h10, 8'h00);
    change_of_flow(1'b0, 3'h0, 17'h1ABCD, 19'h4ABCD);
    rchk(8'h14, 8'h00);
    change_of_flow(1'b1, 3'h5, 17'h03FFF, 19'h77FFF);
    rchk(8'h14, 8'h81);
    event_only_mode <= 1'b1;
    change_of_flow(1'b0, 3'h0, 17'h00222, 19'h0);
    event_only_mode <= 1'b0;
    rchk(8'h2C, 8'h02);
    chk("irq", 18'h0, {17'h0, irq});
    wr(8'h28, 8'h02);
    #1;
    chk("irq", 18'h1, {17'h0, irq});
    wr(8'h24, 8'h02);
    #1;
    chk("irq", 18'h0, {17'h0, irq});
    $display("t_cap done");
  endtask : t_cap
  task t_loop;
    wr(8'h0C, 8'hC1);
    change_of_flow(1'b0, 3'h0, 17'h00111, 19'h40111);
    rchk(8'h18, 8'h00);
    rchk(8'h1C, 8'h01);
    rchk(8'h20, 8'h11);
    change_of_flow(1'b0, 3'h0, 17'h00111, 19'h0);
    rchk(8'h2C, 8'h03);
    $display("t_loop done");
  endtask : t_loop
  task t_end;
    logic seen;
    seen = 1'b0;
    wr(8'h0C, 8'hD0);
    @(posedge clk_sys);
    trig_hit <= 1'b1;
    @(posedge clk_sys);
    trig_hit <= 1'b0;
    repeat (3)
    begin
      #1;
      seen = seen | brk_req;
      @(posedge clk_sys);
    end
    chk("brk_run_end", 18'h1, {17'h0, seen});
    rchk(8'h0C, 8'h90);
    change_of_flow(1'b0, 3'h0, 17'h00333, 19'h0);
    $display("t_end done");
  endtask : t_end
  task t_ern;
    wr(8'h10, 8'hC0);
    wr(8'h0C, 8'h80);
    @(posedge clk_sys);
    end_run_reset <= 1'b1;
    @(posedge clk_sys);
    end_run_reset <= 1'b0;
    rchk(8'h10, 8'hC0);
    trig_begin <= 1'b1;
    @(posedge clk_sys);
    end_run_reset <= 1'b1;
    @(posedge clk_sys);
    end_run_reset <= 1'b0;
    rchk(8'h10, 8'h00);
    $display("t_ern done");
  endtask : t_ern
  // Begin mode: nothing is stored before the trigger, and the eighth word ends the run.
  task t_begin;
    logic [16:0] a;
    wr(8'h0C, 8'hC0);
    change_of_flow(1'b0, 3'h0, 17'h00444, 19'h0);
    @(posedge clk_sys);
    trig_hit <= 1'b1;
    @(posedge clk_sys);
    trig_hit <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      a = 17'h00500 + 17'(i);
      change_of_flow(1'b0, 3'h0, a, {2'b10, a});
    end
    rchk(8'h0C, 8'h80);
    change_of_flow(1'b0, 3'h0, 17'h00600, 19'h0);
    rchk(8'h2C, 8'h08);
    $display("t_begin done");
  endtask : t_begin
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_regs();
    t_cmp();
    t_cap();
    t_loop();
    t_end();
    t_ern();
    t_begin();
    close_out();
  end
  initial
  begin
    #200000;
    miscompares++;
    close_out();
  end
endmodule : dtcc_tb_top
bind dtcc_top dtcc_monitor u_mon (
  .clk_sys(clk_sys),
  .reset_n(reset_n),
  .secure(secure),
  .event_only_mode(event_only_mode),
  .reg_req(reg_req),
  .bus_mon(bus_mon),
  .cof_in(cof_in),
  .reg_rdata(reg_rdata),
  .fifo_wr(fifo_wr),
  .fifo_wdata(fifo_wdata),
  .cmp_c_match(cmp_c_match),
  .brk_req(brk_req),
  .brk_tag(brk_tag)
);
